// file: rtl/deser_pkg.sv
// Shared constants for the serial-to-parallel converter.
package deser_pkg;

    // Width of the parallel word.
    localparam int unsigned WORD_BITS = 4;

    // Width of the phase counter that drives the divided clocks.
    localparam int unsigned PHASE_BITS = 3;

    // Positions of the divide-by-four and divide-by-eight clocks in the phase counter.
    localparam int unsigned QUARTER_POS = 1;
    localparam int unsigned EIGHTH_POS = 2;

    // Phase counts on which a word is complete: the first of two in four-bit mode, the only one in eight-bit mode.
    localparam logic [PHASE_BITS-1:0] LAST_PHASE_FOUR = 3'h3;
    localparam logic [PHASE_BITS-1:0] LAST_PHASE_EIGHT = 3'h7;

    // Low two phase bits that close a four-bit word.
    localparam logic [1:0] LAST_QUARTER_PHASE = 2'h3;

    // Phase counter step.
    localparam logic [PHASE_BITS-1:0] PHASE_STEP = 3'h1;

    // Values after reset.
    localparam logic [PHASE_BITS-1:0] PHASE_RESET = 3'h0;
    localparam logic [WORD_BITS-1:0] WORD_RESET = 4'h0;

    // Pin synchroniser depth and the least alignment pulse, in input clock cycles.
    localparam int unsigned SYNC_STAGES = 3;
    localparam int unsigned ALIGN_MIN_CYCLES = 2;

    // Bit positions of the synchronised control pins.
    localparam int unsigned CTRL_BITS = 3;
    localparam int unsigned CTRL_ALIGN = 0;
    localparam int unsigned CTRL_MODE = 1;
    localparam int unsigned CTRL_SELECT = 2;
    localparam logic [CTRL_BITS-1:0] CTRL_RESET = 3'h0;

endpackage

// file: rtl/pin_sync.sv
// Three-stage synchroniser that only accepts a level once two stages agree.
`timescale 1ns/1ps
module pin_sync
    import deser_pkg::*;
(
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // Asynchronous pins in, filtered levels out.
    input wire logic [CTRL_BITS-1:0] pins,
    output logic [CTRL_BITS-1:0] level
);

    typedef struct packed {
        logic [CTRL_BITS-1:0] s1;
        logic [CTRL_BITS-1:0] s2;
        logic [CTRL_BITS-1:0] s3;
        logic [CTRL_BITS-1:0] level;
    } sync_state_t;

    sync_state_t st_q;
    sync_state_t st_d;

    // The first stage is read by the second stage only, to keep metastability contained.
    always_comb begin
        st_d = st_q;
        if (ce) begin
            st_d.s1 = pins;
            st_d.s2 = st_q.s1;
            st_d.s3 = st_q.s2;
            for (int i = 0; i < CTRL_BITS; i++) begin
                if (st_q.s2[i] == st_q.s3[i]) begin
                    st_d.level[i] = st_q.s2[i];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '{s1: CTRL_RESET, s2: CTRL_RESET, s3: CTRL_RESET, level: CTRL_RESET};
        end else begin
            st_q <= st_d;
        end
    end

    assign level = st_q.level;

endmodule

// file: rtl/deserializer.sv
// Four-bit serial-to-parallel converter with divided clocks and word alignment.
`timescale 1ns/1ps
module deserializer
    import deser_pkg::*;
(
    // Clock, reset and enable.
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CE,
    // Serial data, sampled on CLK.
    input wire logic SERIAL_IN_FIRST,
    input wire logic SERIAL_IN_SECOND,
    // Asynchronous control pins.
    input wire logic SELECT_FIRST,
    input wire logic MODE_EIGHT,
    input wire logic ALIGN_PULSE,
    // Parallel word and divided clocks.
    output logic [WORD_BITS-1:0] PARALLEL_WORD_OUT,
    output logic CLOCK_QUARTER_OUT,
    output logic CLOCK_EIGHTH_OUT
);

    typedef struct packed {
        logic [PHASE_BITS-1:0] phase;
        logic [WORD_BITS-1:0] shift;
        logic [WORD_BITS-1:0] word;
        logic align_seen;
        logic [WORD_BITS-1:0] history;
    } deser_state_t;

    deser_state_t st_q;
    deser_state_t st_d;
    logic [CTRL_BITS-1:0] ctrl_s;
    logic align_s;
    logic mode_s;
    logic select_s;
    logic serial_bit;
    logic slip;
    logic load;
    logic [WORD_BITS-1:0] expect_word;

    // True on the phase that closes a word in the given mode.
    function automatic logic word_done(input logic [PHASE_BITS-1:0] ph, input logic eight);
        word_done = eight ? (ph == LAST_PHASE_EIGHT) : (ph[1:0] == LAST_QUARTER_PHASE);
    endfunction

    // The control pins have no timing relation to CLK, so they are filtered first.
    pin_sync u_pin_sync (
        .clk(CLK),
        .resetn(RESETN),
        .ce(CE),
        .pins({SELECT_FIRST, MODE_EIGHT, ALIGN_PULSE}),
        .level(ctrl_s)
    );

    assign align_s = ctrl_s[CTRL_ALIGN];
    assign mode_s = ctrl_s[CTRL_MODE];
    assign select_s = ctrl_s[CTRL_SELECT];

    assign serial_bit = select_s ? SERIAL_IN_FIRST : SERIAL_IN_SECOND;
    assign slip = align_s & ~st_q.align_seen;
    assign load = word_done(st_q.phase, mode_s) & ~slip;
    assign expect_word = {serial_bit, st_q.history[0], st_q.history[1], st_q.history[2]};

    always_comb begin
        st_d = st_q;
        if (CE) begin
            st_d.align_seen = align_s;
            // A slip holds the phase for one cycle, moving the boundary and both clocks.
            if (!slip) begin
                st_d.phase = st_q.phase + PHASE_STEP;
            end
            st_d.shift = {serial_bit, st_q.shift[WORD_BITS-1:1]};
            st_d.history = {st_q.history[WORD_BITS-2:0], serial_bit};
            // The bit of the closing cycle goes straight into the word, so no cycle is lost.
            if (load) begin
                st_d.word = {serial_bit, st_q.shift[WORD_BITS-1:1]};
            end
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_q <= '{phase: PHASE_RESET, shift: WORD_RESET, word: WORD_RESET,
                      align_seen: 1'b0, history: WORD_RESET};
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs come straight from the state flops, so no decode glitch reaches the pins.
    assign PARALLEL_WORD_OUT = st_q.word;
    assign CLOCK_QUARTER_OUT = st_q.phase[QUARTER_POS];
    assign CLOCK_EIGHTH_OUT = st_q.phase[EIGHTH_POS];

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    phase_step_a: assert property (
        CE && !slip |=> st_q.phase == $past(st_q.phase) + PHASE_STEP
    ) else $error("Phase counter did not advance.");

    slip_hold_a: assert property (
        CE && slip |=> st_q.phase == $past(st_q.phase)
    ) else $error("Slip did not hold the phase for one cycle.");

    slip_once_a: assert property (
        CE && slip |=> !slip
    ) else $error("One alignment pulse slipped more than once.");

    quarter_clock_a: assert property (
        CE && !slip && st_q.phase[0] |=> CLOCK_QUARTER_OUT != $past(CLOCK_QUARTER_OUT)
    ) else $error("Quarter clock did not toggle every two cycles.");

    eighth_clock_a: assert property (
        CE && !slip && st_q.phase[1:0] == LAST_QUARTER_PHASE
        |=> CLOCK_EIGHTH_OUT != $past(CLOCK_EIGHTH_OUT)
    ) else $error("Eighth clock did not toggle every four cycles.");

    clock_slip_a: assert property (
        CE && slip |=> $stable(CLOCK_QUARTER_OUT) && $stable(CLOCK_EIGHTH_OUT)
    ) else $error("Divided clocks moved during a slip.");

    word_order_a: assert property (
        CE && load |=> PARALLEL_WORD_OUT == $past(expect_word)
    ) else $error("Parallel word bits are not in arrival order.");

    word_hold_a: assert property (
        !(CE && load) |=> $stable(PARALLEL_WORD_OUT)
    ) else $error("Parallel word changed outside a word boundary.");

    four_rate_a: assert property (
        CE && !mode_s && !slip && st_q.phase[1:0] == LAST_QUARTER_PHASE
        |=> PARALLEL_WORD_OUT == $past(expect_word)
    ) else $error("Four-bit mode missed a word update.");

    eight_rate_a: assert property (
        $changed(PARALLEL_WORD_OUT) && $past(mode_s)
        |-> $past(st_q.phase) == LAST_PHASE_EIGHT
    ) else $error("Eight-bit mode updated the word off the eighth phase.");

    first_source_a: assert property (
        CE && select_s |=> st_q.shift[WORD_BITS-1] == $past(SERIAL_IN_FIRST)
    ) else $error("Select high did not take the first serial input.");

    second_source_a: assert property (
        CE && !select_s |=> st_q.shift[WORD_BITS-1] == $past(SERIAL_IN_SECOND)
    ) else $error("Select low did not take the second serial input.");

    align_sync_a: assert property (
        slip && $past(CE, 1) && $past(CE, 2) && $past(CE, 3) && $past(CE, 4)
        |-> $past(ALIGN_PULSE, 3) && $past(ALIGN_PULSE, 4)
    ) else $error("Slip acted without a synchronised two-cycle pulse.");

    // Clock enable low must freeze every flop, the pin filter included.
    freeze_all_a: assert property (
        !CE |=> $stable(st_q)
    ) else $error("State moved while the clock enable was low.");

    sync_freeze_a: assert property (
        !CE |=> $stable(ctrl_s)
    ) else $error("Pin filter moved while the clock enable was low.");

    quarter_steady_a: assert property (
        CE && !slip && !st_q.phase[0] |=> $stable(CLOCK_QUARTER_OUT)
    ) else $error("Quarter clock toggled off its half period.");

    eighth_steady_a: assert property (
        CE && !slip && st_q.phase[1:0] != LAST_QUARTER_PHASE |=> $stable(CLOCK_EIGHTH_OUT)
    ) else $error("Eighth clock toggled off its half period.");

    eighth_follow_a: assert property (
        $changed(CLOCK_EIGHTH_OUT) |-> $fell(CLOCK_QUARTER_OUT)
    ) else $error("Eighth clock moved without a falling quarter clock.");

    slip_keeps_data_a: assert property (
        CE && slip |=> st_q.shift[WORD_BITS-1] == $past(serial_bit)
    ) else $error("A slip cycle dropped a serial bit.");

    slip_no_load_a: assert property (
        CE && slip |=> $stable(PARALLEL_WORD_OUT)
    ) else $error("The word loaded in a slip cycle.");

    align_track_a: assert property (
        CE |=> st_q.align_seen == $past(align_s)
    ) else $error("Alignment edge detector lost the filtered level.");

    load_spacing_a: assert property (
        CE && load |=> !load
    ) else $error("Two word loads fell on adjacent cycles.");

    word_four_only_a: assert property (
        CE && !mode_s && load |=> $fell(CLOCK_QUARTER_OUT)
    ) else $error("Four-bit word load was not in step with the quarter clock.");

    word_eight_clock_a: assert property (
        CE && mode_s && load |=> $fell(CLOCK_EIGHTH_OUT)
    ) else $error("Eight-bit word load was not in step with the eighth clock.");

    mid_word_hold_a: assert property (
        CE && mode_s && !slip && st_q.phase == LAST_PHASE_FOUR |=> $stable(PARALLEL_WORD_OUT)
    ) else $error("Eight-bit mode loaded the word halfway through.");

    slip_seen_c: cover property (CE && slip ##1 CE && load);
    eight_word_c: cover property (CE && mode_s && load);
    second_word_c: cover property (CE && !select_s && !mode_s && load);
    two_slips_c: cover property (CE && slip ##[2:20] CE && slip);
    resume_c: cover property (!CE ##1 CE);

endmodule

// file: sim/serial_source.sv
// Serial bit source standing in for the converter feeding the far side.
`timescale 1ns/1ps
module serial_source (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Serial lines and their recent bits, newest in bit 0.
    output logic line_a,
    output logic line_b,
    output logic [7:0] hist_a,
    output logic [7:0] hist_b
);
    logic [15:0] lfsr_q;
    // The two lines carry unrelated streams so a wrong source select shows at once.
    assign line_a = lfsr_q[0];
    assign line_b = lfsr_q[7] ^ lfsr_q[3];
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lfsr_q <= 16'hace1;
            hist_a <= 8'h00;
            hist_b <= 8'h00;
        end else begin
            lfsr_q <= {lfsr_q[0] ^ lfsr_q[2] ^ lfsr_q[3] ^ lfsr_q[5], lfsr_q[15:1]};
            hist_a <= {hist_a[6:0], line_a};
            hist_b <= {hist_b[6:0], line_b};
        end
    end
endmodule

// file: sim/tb.sv
// Self-checking bench for the serial-to-parallel converter.
`timescale 1ns/1ps
module tb;
    import deser_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic sel = 1'b0;
    logic mode8 = 1'b0;
    logic align = 1'b0;
    logic ce = 1'b1;
    logic line_a;
    logic line_b;
    logic [7:0] hist_a;
    logic [7:0] hist_b;
    logic [WORD_BITS-1:0] word;
    logic quarter;
    logic eighth;
    int err_total = 0;
    int n_compared = 0;
    always #12.5 clk = ~clk;
    serial_source src (.clk(clk), .resetn(resetn), .line_a(line_a), .line_b(line_b),
        .hist_a(hist_a), .hist_b(hist_b));
    deserializer dut (.CLK(clk), .RESETN(resetn), .CE(ce), .SERIAL_IN_FIRST(line_a),
        .SERIAL_IN_SECOND(line_b), .SELECT_FIRST(sel), .MODE_EIGHT(mode8),
        .ALIGN_PULSE(align), .PARALLEL_WORD_OUT(word), .CLOCK_QUARTER_OUT(quarter),
        .CLOCK_EIGHTH_OUT(eighth));
    task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d compares %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Watches n cycles; the first load only sets the reference point for gap counting.
    task automatic run(input int n, input logic s, input logic m, input int slips);
        int gap;
        int odd;
        int loads;
        logic qp;
        logic ep;
        logic ld;
        logic [3:0] wp;
        logic [7:0] h;
        gap = -100;
        odd = 0;
        loads = 0;
        sel = s;
        mode8 = m;
        repeat (10) @(posedge clk);
        #1;
        qp = quarter;
        ep = eighth;
        wp = word;
        for (int i = 0; i < n; i++) begin
            align = (i % 12 < 2) && (i / 12 > 0) && (i / 12 <= slips);
            @(posedge clk);
            #1;
            gap++;
            h = s ? hist_a : hist_b;
            ld = m ? (ep && !eighth) : (qp && !quarter);
            if (qp && !quarter) check({3'h0, eighth}, {3'h0, ~ep}, "eighth");
            if (ld) begin
                check(word, {h[0], h[1], h[2], h[3]}, "word");
                if (gap > 0 && gap != (m ? 8 : 4)) odd++;
                gap = 0;
                loads++;
            end else check(word, wp, "stand");
            qp = quarter;
            ep = eighth;
            wp = word;
        end
        check(4'(odd), 4'(slips), "slips");
        check({3'h0, loads > 2}, 4'h1, "loads");
    endtask
    task automatic four_bit_first();
        run(40, 1'b1, 1'b0, 0);
    endtask
    task automatic four_bit_second();
        run(40, 1'b0, 1'b0, 0);
    endtask
    task automatic eight_bit();
        run(64, 1'b1, 1'b1, 0);
    endtask
    // The slips must also keep the divided clocks in step, so gaps are judged on them.
    task automatic slip_pair();
        run(48, 1'b0, 1'b0, 2);
    endtask
    // Clock enable low must freeze the word and both divided clocks.
    task automatic enable_hold();
        logic [3:0] wq;
        logic [1:0] cq;
        wq = word;
        cq = {eighth, quarter};
        ce = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        check(word, wq, "frozen word");
        check({2'h0, eighth, quarter}, {2'h0, cq}, "frozen clocks");
        ce = 1'b1;
    endtask
    // A reset in mid-run must clear the word and both divided clocks at once.
    task automatic reset_mid();
        resetn = 1'b0;
        @(posedge clk);
        #1;
        check(word, WORD_RESET, "reset word");
        check({2'h0, eighth, quarter}, 4'h0, "reset clocks");
        resetn = 1'b1;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1;
        resetn = 1'b1;
        four_bit_first();
        enable_hold();
        four_bit_second();
        eight_bit();
        reset_mid();
        slip_pair();
        stop_test();
    end
    initial begin
        repeat (2000) @(posedge clk);
        err_total++;
        stop_test();
    end
endmodule
